// ### verilog/lt_timer_cells.sv
// Our own choices: the address map and the APB register port.
module lt_timer_cells
   import lt_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Cell inputs from the surrounding logic
   input  wire logic        on_trig,
   input  wire logic        off_trig,
   input  wire logic        off_clear,
   input  wire logic        onoff_trig,
   input  wire logic        ret_trig,
   input  wire logic        ret_clear,
   input  wire logic        latch_set,
   input  wire logic        latch_clear,
   input  wire logic        tog_trig,
   input  wire logic        tog_clear,
   input  wire logic        pout_trig,
   input  wire logic        epls_trig,
   input  wire logic        cnt_pulse,
   input  wire logic        cnt_dir,
   input  wire logic        cnt_clear,
   input  wire logic        clkgen_enable,
   input  wire logic        pgen_enable,
   input  wire logic        output_negate,
   input  wire logic        rate_in,
   // Cell outputs
   output logic             on_q,
   output logic             off_q,
   output logic             onoff_q,
   output logic             ret_q,
   output logic             latch_q,
   output logic             tog_q,
   output logic             pout_q,
   output logic             epls_q,
   output logic             sw_q,
   output logic             cnt_q,
   output logic             clkgen_q,
   output logic             pgen_q,
   output logic             ft_q
);

   localparam lt_state_t ST_RESET = '{cfg: CFG_RESET, default: '0};

   lt_state_t         st;
   lt_state_t         next_st;
   logic [7:0]        cfg_off;
   logic [4:0]        cidx;
   logic              cfg_hit;
   logic              ret_rise;
   logic              tog_rise;
   logic              pout_rise;
   logic              epls_rise;
   logic              cnt_rise;
   logic              rate_rise;

   assign cfg_off   = paddr - CFG_BASE;
   assign cidx      = cfg_off[6:2];
   assign cfg_hit   = (paddr >= CFG_BASE) && (paddr <= CFG_LAST) && (paddr[1:0] == 2'b00);
   assign ret_rise  = ret_trig && !st.prev_ret;
   assign tog_rise  = tog_trig && !st.prev_tog;
   assign pout_rise = pout_trig && !st.prev_pout;
   assign epls_rise = epls_trig && !st.prev_epls;
   assign cnt_rise  = cnt_pulse && !st.prev_cnt;
   assign rate_rise = rate_in && !st.prev_rate;

   always_comb begin
      logic [CFG_W-1:0] lim;
      logic [CFG_W-1:0] pulses;
      lim    = '0;
      pulses = '0;
      next_st = st;

      // APB: answer prepared in setup, pready high in the single access cycle
      next_st.pready = 1'b0;
      if (psel && !penable) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = 1'b0;
         next_st.prdata  = '0;
         if (paddr == ADDR_CTRL) begin
            next_st.prdata[CTRL_REPEAT_BIT] = st.repeat_en;
         end else if (paddr == ADDR_STATUS) begin
            next_st.prdata[NCELL-1:0] = st.q;
         end else if (paddr == ADDR_COUNT) begin
            next_st.prdata[CNT_W-1:0] = st.count;
         end else if (cfg_hit) begin
            next_st.prdata[CFG_W-1:0] = st.cfg[cidx];
         end else begin
            next_st.pslverr = 1'b1;
         end
      end
      if (psel && penable && st.pready && pwrite) begin
         if (paddr == ADDR_CTRL) begin
            next_st.repeat_en = pwdata[CTRL_REPEAT_BIT];
         end else if (cfg_hit) begin
            next_st.cfg[cidx] = pwdata[CFG_W-1:0];
         end
      end

      // Shared time base
      next_st.tick = 1'b0;
      if (st.tdiv >= TDIV_W'(TICK_DIV - 1)) begin
         next_st.tdiv = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.tdiv = st.tdiv + TDIV_W'(1);
      end

      // On delay
      if (!on_trig) begin
         next_st.q[Q_ON]   = 1'b0;
         next_st.tmr[T_ON] = '0;
      end else if (!st.q[Q_ON]) begin
         if (st.tmr[T_ON] >= next_st.cfg[C_ON]) begin
            next_st.q[Q_ON] = 1'b1;
         end else if (st.tick) begin
            next_st.tmr[T_ON] = st.tmr[T_ON] + CFG_W'(1);
         end
      end

      // Off delay
      if (off_clear) begin
         next_st.q[Q_OFF]   = 1'b0;
         next_st.tmr[T_OFF] = '0;
      end else if (off_trig) begin
         next_st.q[Q_OFF]   = 1'b1;
         next_st.tmr[T_OFF] = '0;
      end else if (st.q[Q_OFF]) begin
         if (st.tmr[T_OFF] >= next_st.cfg[C_OFF]) begin
            next_st.q[Q_OFF] = 1'b0;
         end else if (st.tick) begin
            next_st.tmr[T_OFF] = st.tmr[T_OFF] + CFG_W'(1);
         end
      end

      // On/off delay
      lim = onoff_trig ? next_st.cfg[C_ONOFF_ON] : next_st.cfg[C_ONOFF_OFF];
      if (onoff_trig == st.q[Q_ONOFF]) begin
         next_st.tmr[T_ONOFF] = '0;
      end else if (st.tmr[T_ONOFF] >= lim) begin
         next_st.q[Q_ONOFF]   = onoff_trig;
         next_st.tmr[T_ONOFF] = '0;
      end else if (st.tick) begin
         next_st.tmr[T_ONOFF] = st.tmr[T_ONOFF] + CFG_W'(1);
      end

      // Retentive on delay
      if (ret_clear) begin
         next_st.q[Q_RET]   = 1'b0;
         next_st.ret_run    = 1'b0;
         next_st.tmr[T_RET] = '0;
      end else if (st.ret_run) begin
         if (st.tmr[T_RET] >= next_st.cfg[C_RET]) begin
            next_st.q[Q_RET] = 1'b1;
            next_st.ret_run  = 1'b0;
         end else if (st.tick) begin
            next_st.tmr[T_RET] = st.tmr[T_RET] + CFG_W'(1);
         end
      end else if (ret_rise && !st.q[Q_RET]) begin
         next_st.ret_run    = 1'b1;
         next_st.tmr[T_RET] = '0;
      end

      // Latch, clear first
      if (latch_clear) begin
         next_st.q[Q_LATCH] = 1'b0;
      end else if (latch_set) begin
         next_st.q[Q_LATCH] = 1'b1;
      end

      // Toggle relay
      if (tog_clear) begin
         next_st.q[Q_TOG] = 1'b0;
      end else if (tog_rise) begin
         next_st.q[Q_TOG] = !st.q[Q_TOG];
      end

      // Pulse-output relay
      if (!pout_trig) begin
         next_st.q[Q_POUT] = 1'b0;
      end else if (pout_rise) begin
         next_st.q[Q_POUT]   = 1'b1;
         next_st.tmr[T_POUT] = '0;
      end else if (st.q[Q_POUT]) begin
         if (st.tmr[T_POUT] >= next_st.cfg[C_POUT]) begin
            next_st.q[Q_POUT] = 1'b0;
         end else if (st.tick) begin
            next_st.tmr[T_POUT] = st.tmr[T_POUT] + CFG_W'(1);
         end
      end

      // Edge-triggered pulse relay, retriggerable
      if (epls_rise) begin
         next_st.q[Q_EPLS]   = 1'b1;
         next_st.tmr[T_EPLS] = '0;
      end else if (st.q[Q_EPLS]) begin
         if (st.tmr[T_EPLS] >= next_st.cfg[C_EPLS]) begin
            next_st.q[Q_EPLS] = 1'b0;
         end else if (st.tick) begin
            next_st.tmr[T_EPLS] = st.tmr[T_EPLS] + CFG_W'(1);
         end
      end

      // Time switch, time counted from reset
      if (st.tick) begin
         if (st.repeat_en && (st.tmr[T_SW] + CFG_W'(1) >= next_st.cfg[C_SW_PERIOD])) begin
            next_st.tmr[T_SW] = '0;
         end else if (st.tmr[T_SW] != TMR_MAX) begin
            next_st.tmr[T_SW] = st.tmr[T_SW] + CFG_W'(1);
         end
      end
      next_st.q[Q_SW] = (next_st.tmr[T_SW] >= next_st.cfg[C_SW_ON]) &&
                        (next_st.tmr[T_SW] < next_st.cfg[C_SW_OFF]);

      // Up/down counter, saturating at zero and the top of range
      if (cnt_clear) begin
         next_st.count    = '0;
         next_st.q[Q_CNT] = 1'b0;
      end else begin
         if (cnt_rise) begin
            if (cnt_dir) begin
               if (st.count != '0) begin
                  next_st.count = st.count - CNT_W'(1);
               end
            end else if (st.count != CNT_MAX) begin
               next_st.count = st.count + CNT_W'(1);
            end
         end
         next_st.q[Q_CNT] = (CFG_W'(next_st.count) >= next_st.cfg[C_PRESET]);
      end

      // Clock generator, starts with a high phase
      if (!clkgen_enable) begin
         next_st.q[Q_CLK]   = 1'b0;
         next_st.tmr[T_CLK] = '0;
      end else if (!st.prev_clk_en) begin
         next_st.q[Q_CLK]   = 1'b1;
         next_st.tmr[T_CLK] = '0;
      end else if (st.tick) begin
         if (st.tmr[T_CLK] + CFG_W'(1) >= next_st.cfg[C_CLK]) begin
            next_st.q[Q_CLK]   = !st.q[Q_CLK];
            next_st.tmr[T_CLK] = '0;
         end else begin
            next_st.tmr[T_CLK] = st.tmr[T_CLK] + CFG_W'(1);
         end
      end

      // Pulse generator, raw phase kept apart from the negated output
      lim = st.pg_phase ? next_st.cfg[C_PG_HIGH] : next_st.cfg[C_PG_LOW];
      if (!pgen_enable) begin
         next_st.pg_phase  = 1'b0;
         next_st.tmr[T_PG] = '0;
      end else if (!st.prev_pg_en) begin
         next_st.pg_phase  = 1'b1;
         next_st.tmr[T_PG] = '0;
      end else if (st.tick) begin
         if (st.tmr[T_PG] + CFG_W'(1) >= lim) begin
            next_st.pg_phase  = !st.pg_phase;
            next_st.tmr[T_PG] = '0;
         end else begin
            next_st.tmr[T_PG] = st.tmr[T_PG] + CFG_W'(1);
         end
      end
      next_st.q[Q_PG] = pgen_enable && (next_st.pg_phase ^ output_negate);

      // Frequency trigger, thresholds in pulses per interval
      pulses = st.ft_cnt;
      if (rate_rise && (st.ft_cnt != TMR_MAX)) begin
         pulses = st.ft_cnt + CFG_W'(1);
      end
      if (st.tick && (st.tmr[T_FT] + CFG_W'(1) >= next_st.cfg[C_FT_INTERVAL])) begin
         if (pulses > next_st.cfg[C_FT_ON]) begin
            next_st.q[Q_FT] = 1'b1;
         end else if (pulses <= next_st.cfg[C_FT_OFF]) begin
            next_st.q[Q_FT] = 1'b0;
         end
         next_st.ft_cnt   = '0;
         next_st.tmr[T_FT] = '0;
      end else begin
         next_st.ft_cnt = pulses;
         if (st.tick) begin
            next_st.tmr[T_FT] = st.tmr[T_FT] + CFG_W'(1);
         end
      end

      next_st.q[Q_SPARE] = 1'b0;
      next_st.prev_ret    = ret_trig;
      next_st.prev_tog    = tog_trig;
      next_st.prev_pout   = pout_trig;
      next_st.prev_epls   = epls_trig;
      next_st.prev_cnt    = cnt_pulse;
      next_st.prev_clk_en = clkgen_enable;
      next_st.prev_pg_en  = pgen_enable;
      next_st.prev_rate   = rate_in;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata   = st.prdata;
   assign pready   = st.pready;
   assign pslverr  = st.pslverr;
   assign on_q     = st.q[Q_ON];
   assign off_q    = st.q[Q_OFF];
   assign onoff_q  = st.q[Q_ONOFF];
   assign ret_q    = st.q[Q_RET];
   assign latch_q  = st.q[Q_LATCH];
   assign tog_q    = st.q[Q_TOG];
   assign pout_q   = st.q[Q_POUT];
   assign epls_q   = st.q[Q_EPLS];
   assign sw_q     = st.q[Q_SW];
   assign cnt_q    = st.q[Q_CNT];
   assign clkgen_q = st.q[Q_CLK];
   assign pgen_q   = st.q[Q_PG];
   assign ft_q     = st.q[Q_FT];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access_done;
      pready ##1 !pready;
   endsequence

   a_apb_one_wait: assert property (s_setup |=> s_access_done)
      else $error("apb access did not complete in one cycle");
   a_on_low_clear: assert property (!on_trig |=> !on_q)
      else $error("on delay output high with trigger low");
   a_on_no_early: assert property ($rose(on_trig) && (st.cfg[C_ON] != '0) |=> !on_q)
      else $error("on delay output rose too early");
   a_off_rise_high: assert property (off_trig && !off_clear |=> off_q)
      else $error("off delay output not high with trigger");
   a_off_clear_low: assert property (off_clear |=> !off_q)
      else $error("off delay clear did not drop output");
   a_onoff_rev_hold: assert property (onoff_trig == onoff_q |=> $stable(onoff_q))
      else $error("on off delay output changed without delay");
   a_ret_retained: assert property (ret_q && !ret_clear |=> ret_q)
      else $error("retentive output lost without clear");
   a_latch_clear_wins: assert property (latch_clear |=> !latch_q)
      else $error("latch clear did not win");
   a_latch_hold: assert property (!latch_set && !latch_clear |=> $stable(latch_q))
      else $error("latch changed with no input");
   a_tog_flip: assert property (tog_rise && !tog_clear |=> tog_q != $past(tog_q))
      else $error("toggle output did not invert");
   a_pout_fall: assert property (!pout_trig |=> !pout_q)
      else $error("pulse relay high after trigger fell");
   a_epls_start: assert property (epls_rise && (st.cfg[C_EPLS] != '0) |=> epls_q [*2])
      else $error("edge pulse relay not high after edge");
   a_cnt_clear: assert property (cnt_clear |=> !cnt_q && (st.count == '0))
      else $error("counter not held clear");
   a_cnt_up: assert property (cnt_rise && !cnt_dir && !cnt_clear && (st.count != CNT_MAX)
                              |=> st.count == $past(st.count) + CNT_W'(1))
      else $error("counter did not count up");
   a_cnt_compare: assert property (!$past(cnt_clear) |->
                                   cnt_q == (CFG_W'(st.count) >= st.cfg[C_PRESET]))
      else $error("counter output disagrees with preset compare");
   a_clk_stopped: assert property (!clkgen_enable |=> !clkgen_q)
      else $error("clock generator runs while disabled");
   a_pg_disabled: assert property (!pgen_enable |=> !pgen_q)
      else $error("pulse generator output high while disabled");
   a_tick_spacing: assert property (st.tick |=> !st.tick)
      else $error("time base tick too frequent");

endmodule

// ### verilog/lt_pkg.sv
// Notes on behaviour
// - On-delay output rises once the trigger has stayed high for the delay.
// - On-delay timer clears and output drops whenever the trigger is low.
// - Off-delay output rises at once; falling trigger starts the off delay.
// - New on-off sequence restarts the off delay; clear cancels it and drops output.
// - On/off-delay output follows the trigger after the matching configured delay.
// - Trigger reversal during a running on/off delay clears it; output keeps level.
// - Retentive timer starts on rising trigger, ignores trigger later, only clear resets.
// - Latch set drives high, clear drives low, otherwise the output holds.
// - Toggle output inverts on each rising trigger; clear returns it low.
// - Pulse relay high while trigger high, until time expires or trigger falls.
// - Edge pulse relay stays high for the time; new rising edge restarts it.
// - Time switch high from on time to off time, repeating each period if enabled.
// - Counter adds one on rising count pulse when direction low, subtracts when high.
// - Counter output high whenever the count is at or above the preset.
// - Counter clear holds count zero, output low, and ignores count pulses.
// - Clock generator alternates phases of the pulse time while enabled, stops otherwise.
// - Pulse generator uses separately configured high and low durations.
// - Negate input inverts the pulse generator output only while enabled.
// - Frequency trigger counts pulses per interval; output rises above the on threshold.
// - Frequency trigger output falls at or below the off threshold.
package lt_pkg;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_TIME_NS   = 500000;
   localparam int TICK_CYCLES    = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TDIV_W         = 17;

   localparam int CFG_W = 24;
   localparam int CNT_W = 14;
   localparam int NCFG  = 17;
   localparam int NTMR  = 10;
   localparam int NCELL = 14;

   localparam logic [CNT_W-1:0] CNT_MAX = 14'h270F;
   localparam logic [CFG_W-1:0] TMR_MAX = 24'hFFFFFF;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT  = 8'h08;
   localparam logic [7:0] CFG_BASE    = 8'h0C;
   localparam logic [7:0] CFG_LAST    = 8'h4C;
   localparam int         CTRL_REPEAT_BIT = 0;

   // Configuration word indices, durations in ticks
   localparam int C_ON = 0, C_OFF = 1, C_ONOFF_ON = 2, C_ONOFF_OFF = 3, C_RET = 4;
   localparam int C_POUT = 5, C_EPLS = 6, C_SW_ON = 7, C_SW_OFF = 8, C_SW_PERIOD = 9;
   localparam int C_PRESET = 10, C_CLK = 11, C_PG_HIGH = 12, C_PG_LOW = 13;
   localparam int C_FT_INTERVAL = 14, C_FT_ON = 15, C_FT_OFF = 16;

   // Timer indices
   localparam int T_ON = 0, T_OFF = 1, T_ONOFF = 2, T_RET = 3, T_POUT = 4;
   localparam int T_EPLS = 5, T_SW = 6, T_CLK = 7, T_PG = 8, T_FT = 9;

   // Cell output bits, also the status register layout
   localparam int Q_ON = 0, Q_OFF = 1, Q_ONOFF = 2, Q_RET = 3, Q_LATCH = 4, Q_TOG = 5;
   localparam int Q_POUT = 6, Q_EPLS = 7, Q_SW = 8, Q_CNT = 9, Q_CLK = 10, Q_PG = 11;
   localparam int Q_FT = 12, Q_SPARE = 13;

   // Reset values: 3 s, 3 s, 3 s, 6 s, 3 s, 3 s, 3 s, 10 s, 30 s, 60 s,
   // preset 5, 0.5 s, 3 s, 1 s, 5 s, 30 and 10 pulses per interval
   localparam logic [NCFG-1:0][CFG_W-1:0] CFG_RESET = {
      24'h00000A, 24'h00001E, 24'h002710, 24'h0007D0, 24'h001770, 24'h0003E8,
      24'h000005, 24'h01D4C0, 24'h00EA60, 24'h004E20, 24'h001770, 24'h001770,
      24'h001770, 24'h002EE0, 24'h001770, 24'h001770, 24'h001770};

   typedef struct packed {
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
      logic                        repeat_en;
      logic [NCFG-1:0][CFG_W-1:0]  cfg;
      logic [TDIV_W-1:0]           tdiv;
      logic                        tick;
      logic [NTMR-1:0][CFG_W-1:0]  tmr;
      logic [NCELL-1:0]            q;
      logic                        ret_run;
      logic                        pg_phase;
      logic [CNT_W-1:0]            count;
      logic [CFG_W-1:0]            ft_cnt;
      logic                        prev_ret;
      logic                        prev_tog;
      logic                        prev_pout;
      logic                        prev_epls;
      logic                        prev_cnt;
      logic                        prev_clk_en;
      logic                        prev_pg_en;
      logic                        prev_rate;
   } lt_state_t;
endpackage

// ### tb/lt_logic_peer.sv
module lt_logic_peer (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Pulse spacing in cycles, zero for silence
   input  wire logic [7:0] rate_period,
   // Pulse train into the frequency trigger
   output logic            rate_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         rate_in <= 1'b0;
      end else begin
         cnt <= (cnt + 8'h01 >= rate_period) ? 8'h00 : cnt + 8'h01;
         rate_in <= (rate_period != 8'h00) && (cnt == 8'h00);
      end
   end
endmodule

// ### tb/lt_timer_cells_test.sv
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp); \
   end \
end

module lt_timer_cells_test
   import lt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, rate_period;
   logic [31:0] pwdata, prdata, rd;
   logic on_trig, off_trig, off_clear, onoff_trig, ret_trig, ret_clear, latch_set;
   logic latch_clear, tog_trig, tog_clear, pout_trig, epls_trig, cnt_pulse, cnt_dir;
   logic cnt_clear, clkgen_enable, pgen_enable, output_negate, rate_in;
   logic on_q, off_q, onoff_q, ret_q, latch_q, tog_q, pout_q, epls_q, sw_q;
   logic cnt_q, clkgen_q, pgen_q, ft_q;
   logic [12:0] qv;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          n;
   int          cv [NCFG] = '{3, 3, 3, 6, 3, 3, 3, 5, 10, 20, 5, 2, 3, 1, 10, 5, 2};

   assign qv = {ft_q, pgen_q, clkgen_q, cnt_q, sw_q, epls_q, pout_q, tog_q, latch_q,
                ret_q, onoff_q, off_q, on_q};

   lt_timer_cells #(.TICK_DIV(4)) u_lt_timer_cells (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .on_trig, .off_trig,
      .off_clear, .onoff_trig, .ret_trig, .ret_clear, .latch_set, .latch_clear,
      .tog_trig, .tog_clear, .pout_trig, .epls_trig, .cnt_pulse, .cnt_dir, .cnt_clear,
      .clkgen_enable, .pgen_enable, .output_negate, .rate_in, .on_q, .off_q, .onoff_q,
      .ret_q, .latch_q, .tog_q, .pout_q, .epls_q, .sw_q, .cnt_q, .clkgen_q, .pgen_q,
      .ft_q);

   lt_logic_peer u_lt_logic_peer (.pclk, .presetn, .rate_period, .rate_in);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Cycles until a cell output shows the level, capped
   task automatic until_q(input int b, input logic l, input int cap);
      n = 0;
      while (qv[b] !== l && n < cap) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task print_verdict;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, rate_period} = '0;
      {on_trig, off_trig, off_clear, onoff_trig, ret_trig, ret_clear, latch_set} = '0;
      {latch_clear, tog_trig, tog_clear, pout_trig, epls_trig, cnt_pulse} = '0;
      {cnt_dir, cnt_clear, clkgen_enable, pgen_enable, output_negate} = '0;
      presetn = 1'b0;
      cyc(20);
      presetn <= 1'b1;
      cyc(1);
      // Defaults, then short durations in ticks
      for (int i = 0; i < NCFG; i++) begin
         apb(0, CFG_BASE + 8'(4 * i), 32'h0);
         `CHK(rd, {8'h00, CFG_RESET[i]})
         apb(1, CFG_BASE + 8'(4 * i), 32'(cv[i]) | 32'hFF000000);
         apb(0, CFG_BASE + 8'(4 * i), 32'h0);
         `CHK(rd, 32'(cv[i]))
      end
      apb(0, 8'h80, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      apb(1, ADDR_CTRL, 32'h1);
      apb(0, ADDR_CTRL, 32'h0);
      `CHK(rd, 32'h1)
      on_trig <= 1'b1;
      cyc(8);
      `CHK(on_q, 1'b0)
      cyc(12);
      `CHK(on_q, 1'b1)
      on_trig <= 1'b0;
      cyc(2);
      `CHK(on_q, 1'b0)
      on_trig <= 1'b1;
      cyc(8);
      on_trig <= 1'b0;
      cyc(2);
      on_trig <= 1'b1;
      cyc(8);
      `CHK(on_q, 1'b0)
      on_trig <= 1'b0;
      off_trig <= 1'b1;
      cyc(2);
      `CHK(off_q, 1'b1)
      off_trig <= 1'b0;
      cyc(8);
      `CHK(off_q, 1'b1)
      cyc(12);
      `CHK(off_q, 1'b0)
      off_trig <= 1'b1;
      cyc(2);
      off_trig <= 1'b0;
      cyc(8);
      off_trig <= 1'b1;
      cyc(2);
      off_trig <= 1'b0;
      cyc(10);
      `CHK(off_q, 1'b1)
      off_clear <= 1'b1;
      cyc(2);
      `CHK(off_q, 1'b0)
      off_clear <= 1'b0;
      onoff_trig <= 1'b1;
      cyc(8);
      `CHK(onoff_q, 1'b0)
      cyc(12);
      `CHK(onoff_q, 1'b1)
      onoff_trig <= 1'b0;
      cyc(8);
      onoff_trig <= 1'b1;
      cyc(30);
      `CHK(onoff_q, 1'b1)
      onoff_trig <= 1'b0;
      cyc(20);
      `CHK(onoff_q, 1'b1)
      cyc(12);
      `CHK(onoff_q, 1'b0)
      ret_trig <= 1'b1;
      cyc(1);
      ret_trig <= 1'b0;
      cyc(8);
      `CHK(ret_q, 1'b0)
      cyc(12);
      `CHK(ret_q, 1'b1)
      ret_trig <= 1'b1;
      cyc(4);
      ret_trig <= 1'b0;
      cyc(4);
      `CHK(ret_q, 1'b1)
      ret_clear <= 1'b1;
      cyc(2);
      `CHK(ret_q, 1'b0)
      ret_clear <= 1'b0;
      latch_set <= 1'b1;
      cyc(2);
      `CHK(latch_q, 1'b1)
      latch_set <= 1'b0;
      cyc(3);
      `CHK(latch_q, 1'b1)
      apb(0, ADDR_STATUS, 32'h0);
      `CHK(rd & ~(32'h1 << Q_SW), 32'h1 << Q_LATCH)
      latch_set <= 1'b1;
      latch_clear <= 1'b1;
      cyc(2);
      `CHK(latch_q, 1'b0)
      {latch_set, latch_clear} <= 2'h0;
      for (int i = 0; i < 3; i++) begin
         tog_trig <= 1'b1;
         cyc(2);
         `CHK(tog_q, ~i[0])
         tog_trig <= 1'b0;
         cyc(2);
      end
      {tog_clear, tog_trig} <= 2'h3;
      cyc(2);
      `CHK(tog_q, 1'b0)
      {tog_clear, tog_trig} <= 2'h0;
      pout_trig <= 1'b1;
      cyc(2);
      `CHK(pout_q, 1'b1)
      cyc(18);
      `CHK(pout_q, 1'b0)
      pout_trig <= 1'b0;
      cyc(2);
      pout_trig <= 1'b1;
      cyc(6);
      `CHK(pout_q, 1'b1)
      pout_trig <= 1'b0;
      cyc(2);
      `CHK(pout_q, 1'b0)
      for (int i = 0; i < 2; i++) begin
         epls_trig <= 1'b1;
         cyc(1);
         epls_trig <= 1'b0;
         cyc(6);
      end
      cyc(4);
      `CHK(epls_q, 1'b1)
      cyc(12);
      `CHK(epls_q, 1'b0)
      // Counts 1 2 3 4 5 4 5 against preset 5
      for (int i = 1; i <= 7; i++) begin
         cnt_dir <= (i == 6);
         cnt_pulse <= 1'b1;
         cyc(1);
         cnt_pulse <= 1'b0;
         cyc(2);
         apb(0, ADDR_COUNT, 32'h0);
         `CHK(rd, 32'(i - 2 * (i > 5)))
         `CHK(cnt_q, logic'(i - 2 * (i > 5) >= 5))
      end
      {cnt_clear, cnt_dir} <= 2'h2;
      cyc(1);
      cnt_pulse <= 1'b1;
      cyc(1);
      cnt_pulse <= 1'b0;
      cyc(2);
      apb(0, ADDR_COUNT, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(cnt_q, 1'b0)
      cnt_clear <= 1'b0;
      clkgen_enable <= 1'b1;
      until_q(Q_CLK, 1, 4);
      `CHK(n < 4, 1'b1)
      until_q(Q_CLK, 0, 20);
      until_q(Q_CLK, 1, 20);
      `CHK(n inside {[7:9]}, 1'b1)
      until_q(Q_CLK, 0, 20);
      `CHK(n inside {[7:9]}, 1'b1)
      clkgen_enable <= 1'b0;
      cyc(2);
      until_q(Q_CLK, 1, 30);
      `CHK(n, 30)
      pgen_enable <= 1'b1;
      cyc(2);
      `CHK(pgen_q, 1'b1)
      until_q(Q_PG, 0, 30);
      `CHK(n inside {[8:14]}, 1'b1)
      until_q(Q_PG, 1, 30);
      `CHK(n inside {[3:5]}, 1'b1)
      output_negate <= 1'b1;
      cyc(2);
      `CHK(pgen_q, 1'b0)
      pgen_enable <= 1'b0;
      cyc(2);
      until_q(Q_PG, 1, 30);
      `CHK(n, 30)
      // Interval of 40 cycles: 10, 4, then 1 or 2 pulses
      rate_period <= 8'h04;
      until_q(Q_FT, 1, 120);
      `CHK(n < 120, 1'b1)
      rate_period <= 8'h0A;
      until_q(Q_FT, 0, 120);
      `CHK(n, 120)
      rate_period <= 8'h1E;
      until_q(Q_FT, 0, 120);
      `CHK(n < 120, 1'b1)
      until_q(Q_SW, 0, 100);
      until_q(Q_SW, 1, 100);
      `CHK(n < 100, 1'b1)
      until_q(Q_SW, 0, 40);
      `CHK(n inside {[19:21]}, 1'b1)
      until_q(Q_SW, 1, 100);
      `CHK(n inside {[59:61]}, 1'b1)
      print_verdict;
   end

   initial begin
      cyc(20000);
      num_errors++;
      print_verdict;
   end
endmodule
